// >>> rtl/stc_serial_time_tx.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - The start bit of each second's on-time character begins no later than 100 us after the epoch.
// - At 19200 baud or faster the on-time character goes out within the first millisecond.
// - Time strings are sent from power-up on without any configuration.
// - The bit rate is selectable among 57600, 19200, 9600 and 4800 baud.
// - Parity is odd, even or none, with the matching bit appended or omitted.
// - A format selector picks one of six layouts, of which the first three are built here.
// - The UTC-fixed string is SOH, day, colon, hour, colon, minute, colon, second, quality, CR, LF.
// - The quality character is space when locked and question mark when unsynchronized.
// - In the UTC-fixed layout the CR is the on-time character, followed by LF.
// - The UTC-fixed format always carries UTC whatever the time mode.
// - The mode-time format uses the UTC-fixed layout with time in the configured mode.
// - The mode-extended format carries time in the configured mode, once each second.
// - In the mode-extended format the leading figure of merit character is the on-time character.
// - The mode-extended string ends with a time mode letter G, L or U before CR LF.
// - The mode-extended offset is a sign and half-hour magnitude, nonzero only in local mode.
module stc_serial_time_tx #(
	parameter int unsigned BIT_CYC_19200 = stc_pkg::CLK_HZ / stc_pkg::BAUD_19200,
	parameter int unsigned BIT_CYC_9600  = stc_pkg::CLK_HZ / stc_pkg::BAUD_9600,
	parameter int unsigned BIT_CYC_4800  = stc_pkg::CLK_HZ / stc_pkg::BAUD_4800
) (
	input  wire logic                CLK,
	input  wire logic                RST,
	input  wire logic                HSEL,
	input  wire logic [31:0]         HADDR,
	input  wire logic [1:0]          HTRANS,
	input  wire logic                HWRITE,
	input  wire logic [2:0]          HSIZE,
	input  wire logic [31:0]         HWDATA,
	input  wire logic                HREADY,
	output logic      [31:0]         HRDATA,
	output logic                     HREADYOUT,
	output logic                     HRESP,
	input  wire logic                EPOCH,
	input  wire stc_pkg::stc_time_s  UTC_TIME,
	input  wire stc_pkg::stc_time_s  MODE_TIME,
	input  wire stc_pkg::stc_status_s DEV_STATUS,
	output logic                     TXD
);
	import stc_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP} stc_state_e;

	stc_ctrl_s   ctrl_q;
	stc_ctrl_s   lat_ctrl_q;
	stc_time_s   lat_time_q;
	stc_status_s lat_stat_q;
	stc_status_s stat_clean;
	stc_state_e  st_q;
	stc_state_e  st_d;
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic [2:0]  bit_q;
	logic [2:0]  bit_d;
	logic [4:0]  idx_q;
	logic [4:0]  idx_d;
	logic        pend_q;
	logic        txd_q;
	logic        txd_d;
	logic [15:0] sent_q;
	logic        wr_pend_q;
	logic [11:0] wr_addr_q;
	logic [31:0] hrdata_q;
	logic [7:0]  ch_fixed;
	logic [7:0]  ch_ext;

	function automatic logic [15:0] bit_len(input logic [1:0] sel);
		logic [15:0] len;
		len = 16'(BIT_CYC_57600);
		case (sel)
			BAUD_SEL_19200: len = 16'(BIT_CYC_19200);
			BAUD_SEL_9600:  len = 16'(BIT_CYC_9600);
			BAUD_SEL_4800:  len = 16'(BIT_CYC_4800);
			default:        len = 16'(BIT_CYC_57600);
		endcase
		return len - 16'h0001;
	endfunction : bit_len

	function automatic logic [7:0] asc(input logic [3:0] digit);
		return {DIGIT_HI, digit};
	endfunction : asc

	// AHB-Lite slave: zero wait states, always OKAY
	wire        ahb_take  = HSEL && HTRANS[1] && HREADY;
	wire [11:0] ahb_ofs   = HADDR[11:0];
	wire        busy      = (st_q != ST_IDLE);
	wire [31:0] ctrl_word = {25'h0, ctrl_q};
	wire [31:0] stat_word = {sent_q, 14'h0, pend_q, busy};
	wire [31:0] rd_mux    = (ahb_ofs == CTRL_OFS) ? ctrl_word :
	                        (ahb_ofs == STAT_OFS) ? stat_word : 32'h00000000;
	wire        ctrl_wr   = wr_pend_q && (wr_addr_q == CTRL_OFS);

	assign HRDATA    = hrdata_q;
	assign HREADYOUT = 1'b1;
	assign HRESP     = 1'b0;

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 12'h000;
			hrdata_q  <= 32'h00000000;
		end
		else
		begin
			wr_pend_q <= ahb_take && HWRITE;
			wr_addr_q <= ahb_ofs;
			if (ahb_take && !HWRITE)
				hrdata_q <= rd_mux;
		end
	end

	// Reset value selects a defined format, so strings start without setup
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			ctrl_q <= CTRL_RST;
		else if (ctrl_wr)
			ctrl_q <= HWDATA[6:0];
	end

	// Launch at the epoch, or at the next character boundary if a string overran the second
	wire launch    = (EPOCH || pend_q) && (!busy || (st_q == ST_STOP && cnt_q == 16'h0000));
	wire fmt_ok    = (ctrl_q.fmt <= FMT_MODE_EXT);
	wire new_utc   = (ctrl_q.fmt == FMT_UTC_FIXED);
	wire is_ext    = (lat_ctrl_q.fmt == FMT_MODE_EXT);
	wire par_on    = (lat_ctrl_q.par == PAR_ODD) || (lat_ctrl_q.par == PAR_EVEN);
	wire bit_end   = (cnt_q == 16'h0000);
	wire [4:0] last_idx = is_ext ? LAST_IDX_EXT : LAST_IDX_FIXED;
	wire [7:0] cur_char = is_ext ? ch_ext : ch_fixed;
	wire par_bit   = (lat_ctrl_q.par == PAR_ODD) ? ~^cur_char : ^cur_char;
	wire str_done  = (st_q == ST_STOP) && bit_end && (idx_q == last_idx);

	// Offset magnitude is forced to zero outside local mode
	always_comb
	begin
		stat_clean = DEV_STATUS;
		if (DEV_STATUS.tmode != TMODE_LOCAL)
			stat_clean.offset_mag = 8'h00;
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			lat_ctrl_q <= CTRL_RST;
			lat_time_q <= '0;
			lat_stat_q <= '0;
		end
		else if (launch)
		begin
			lat_ctrl_q <= ctrl_q;
			lat_time_q <= new_utc ? UTC_TIME : MODE_TIME;
			lat_stat_q <= stat_clean;
		end
	end

	// Fixed layout: CR LF mark this second, then the next second's prefix waits for its CR
	always_comb
	begin
		ch_fixed = CH_CR;
		case (idx_q)
			5'h01: ch_fixed = CH_LF;
			5'h02: ch_fixed = CH_SOH;
			5'h03: ch_fixed = asc(lat_time_q.doy[11:8]);
			5'h04: ch_fixed = asc(lat_time_q.doy[7:4]);
			5'h05: ch_fixed = asc(lat_time_q.doy[3:0]);
			5'h06: ch_fixed = CH_COLON;
			5'h07: ch_fixed = asc(lat_time_q.hour[7:4]);
			5'h08: ch_fixed = asc(lat_time_q.hour[3:0]);
			5'h09: ch_fixed = CH_COLON;
			5'h0a: ch_fixed = asc(lat_time_q.minute[7:4]);
			5'h0b: ch_fixed = asc(lat_time_q.minute[3:0]);
			5'h0c: ch_fixed = CH_COLON;
			5'h0d: ch_fixed = asc(lat_time_q.second[7:4]);
			5'h0e: ch_fixed = asc(lat_time_q.second[3:0]);
			5'h0f: ch_fixed = lat_stat_q.locked ? CH_SPACE : CH_QMARK;
			default: ch_fixed = CH_CR;
		endcase
	end

	// Extended layout: figure of merit first, so it rides on the epoch
	always_comb
	begin
		ch_ext = CH_SPACE;
		case (idx_q)
			5'h00: ch_ext = asc(lat_stat_q.fom);
			5'h02: ch_ext = asc(lat_time_q.year[15:12]);
			5'h03: ch_ext = asc(lat_time_q.year[11:8]);
			5'h04: ch_ext = asc(lat_time_q.year[7:4]);
			5'h05: ch_ext = asc(lat_time_q.year[3:0]);
			5'h07: ch_ext = asc(lat_time_q.doy[11:8]);
			5'h08: ch_ext = asc(lat_time_q.doy[7:4]);
			5'h09: ch_ext = asc(lat_time_q.doy[3:0]);
			5'h0b: ch_ext = asc(lat_time_q.hour[7:4]);
			5'h0c: ch_ext = asc(lat_time_q.hour[3:0]);
			5'h0d: ch_ext = CH_COLON;
			5'h0e: ch_ext = asc(lat_time_q.minute[7:4]);
			5'h0f: ch_ext = asc(lat_time_q.minute[3:0]);
			5'h10: ch_ext = CH_COLON;
			5'h11: ch_ext = asc(lat_time_q.second[7:4]);
			5'h12: ch_ext = asc(lat_time_q.second[3:0]);
			5'h14: ch_ext = lat_stat_q.offset_neg ? CH_MINUS : CH_PLUS;
			5'h15: ch_ext = asc(lat_stat_q.offset_mag[7:4]);
			5'h16: ch_ext = asc(lat_stat_q.offset_mag[3:0]);
			5'h18: ch_ext = (lat_stat_q.tmode == TMODE_CDMA) ? CH_G :
			                (lat_stat_q.tmode == TMODE_LOCAL) ? CH_L : CH_U;
			5'h19: ch_ext = CH_CR;
			5'h1a: ch_ext = CH_LF;
			default: ch_ext = CH_SPACE;
		endcase
	end

	always_comb
	begin
		st_d  = st_q;
		bit_d = bit_q;
		idx_d = idx_q;
		cnt_d = busy ? (bit_end ? bit_len(lat_ctrl_q.baud) : cnt_q - 16'h0001) : cnt_q;
		if (launch)
		begin
			st_d  = fmt_ok ? ST_START : ST_IDLE;
			idx_d = 5'h00;
			cnt_d = bit_len(ctrl_q.baud);
		end
		else if (bit_end)
		begin
			unique case (st_q)
				ST_IDLE: st_d = ST_IDLE;
				ST_START:
				begin
					st_d  = ST_DATA;
					bit_d = 3'h0;
				end
				ST_DATA:
				begin
					if (bit_q == 3'h7)
						st_d = par_on ? ST_PARITY : ST_STOP;
					else
						bit_d = bit_q + 3'h1;
				end
				ST_PARITY: st_d = ST_STOP;
				ST_STOP:
				begin
					if (idx_q == last_idx)
						st_d = ST_IDLE;
					else
					begin
						st_d  = ST_START;
						idx_d = idx_q + 5'h01;
					end
				end
			endcase
		end
	end

	always_comb
	begin
		txd_d = 1'b1;
		unique case (st_q)
			ST_IDLE:   txd_d = 1'b1;
			ST_START:  txd_d = 1'b0;
			ST_DATA:   txd_d = cur_char[bit_q];
			ST_PARITY: txd_d = par_bit;
			ST_STOP:   txd_d = 1'b1;
		endcase
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			st_q   <= ST_IDLE;
			cnt_q  <= 16'h0000;
			bit_q  <= 3'h0;
			idx_q  <= 5'h00;
			txd_q  <= 1'b1;
		end
		else
		begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			bit_q  <= bit_d;
			idx_q  <= idx_d;
			txd_q  <= txd_d;
		end
	end

	// Epoch seen mid-character is held; a launch clears it even if a new epoch comes in the same cycle
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			pend_q <= 1'b0;
			sent_q <= 16'h0000;
		end
		else
		begin
			pend_q <= (EPOCH && !launch) || (pend_q && !launch);
			if (str_done)
				sent_q <= sent_q + 16'h0001;
		end
	end

	assign TXD = txd_q;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);

	a_start_latency: assert property (EPOCH && !busy && fmt_ok |-> ##2 !TXD)
		else $error("start bit not begun two cycles after epoch");
	a_fixed_ontime: assert property (launch && fmt_ok && ctrl_q.fmt != FMT_MODE_EXT |=> cur_char == CH_CR)
		else $error("fixed layout does not open with carriage return");
	a_ext_ontime: assert property (launch && ctrl_q.fmt == FMT_MODE_EXT
		|=> cur_char == {DIGIT_HI, $past(DEV_STATUS.fom)})
		else $error("extended layout does not open with figure of merit");
	a_stop_high: assert property (st_q == ST_STOP |=> TXD)
		else $error("stop bit not high");
	a_parity_value: assert property (st_q == ST_PARITY && lat_ctrl_q.par == PAR_ODD |=> TXD == ~^cur_char)
		else $error("odd parity bit wrong");
	a_no_parity: assert property (st_q == ST_DATA && bit_q == 3'h7 && bit_end && !launch
		&& lat_ctrl_q.par == PAR_NONE |=> st_q == ST_STOP)
		else $error("parity bit sent with parity off");
	a_bit_timing: assert property (busy && $changed(st_q) && !$past(launch) |-> $past(bit_end))
		else $error("bit ended before its period");
	a_quality_char: assert property (busy && !is_ext && idx_q == 5'h0f
		|-> cur_char == (lat_stat_q.locked ? CH_SPACE : CH_QMARK))
		else $error("quality character wrong");
	a_offset_zero: assert property (busy && is_ext && lat_stat_q.tmode != TMODE_LOCAL
		&& (idx_q == 5'h15 || idx_q == 5'h16) |-> cur_char == asc(4'h0))
		else $error("offset nonzero outside local mode");
	a_utc_source: assert property (launch && new_utc |=> lat_time_q == $past(UTC_TIME))
		else $error("fixed format not carrying utc");
	a_mode_letter: assert property (busy && is_ext && idx_q == 5'h18
		|-> cur_char == CH_G || cur_char == CH_L || cur_char == CH_U)
		else $error("time mode letter wrong");
endmodule : stc_serial_time_tx
`default_nettype wire

// >>> rtl/stc_pkg.sv
package stc_pkg;
	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned BAUD_57600    = 57600;
	localparam int unsigned BAUD_19200    = 19200;
	localparam int unsigned BAUD_9600     = 9600;
	localparam int unsigned BAUD_4800     = 4800;
	localparam int unsigned BIT_CYC_57600 = CLK_HZ / BAUD_57600;

	localparam logic [1:0] BAUD_SEL_57600 = 2'h0;
	localparam logic [1:0] BAUD_SEL_19200 = 2'h1;
	localparam logic [1:0] BAUD_SEL_9600  = 2'h2;
	localparam logic [1:0] BAUD_SEL_4800  = 2'h3;

	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_ODD  = 2'h1;
	localparam logic [1:0] PAR_EVEN = 2'h2;

	localparam logic [2:0] FMT_UTC_FIXED = 3'h0;
	localparam logic [2:0] FMT_MODE_TIME = 3'h1;
	localparam logic [2:0] FMT_MODE_EXT  = 3'h2;
	localparam logic [2:0] FMT_LEAP_EXT  = 3'h3;
	localparam logic [2:0] FMT_NENA      = 3'h4;
	localparam logic [2:0] FMT_NMEA      = 3'h5;

	localparam logic [1:0] TMODE_CDMA  = 2'h0;
	localparam logic [1:0] TMODE_LOCAL = 2'h1;
	localparam logic [1:0] TMODE_UTC   = 2'h2;

	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] STAT_OFS = 12'h004;

	localparam logic [4:0] LAST_IDX_FIXED = 5'h0f;
	localparam logic [4:0] LAST_IDX_EXT   = 5'h1a;

	localparam logic [7:0] CH_SOH   = 8'h01;
	localparam logic [7:0] CH_COLON = 8'h3a;
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_QMARK = 8'h3f;
	localparam logic [7:0] CH_CR    = 8'h0d;
	localparam logic [7:0] CH_LF    = 8'h0a;
	localparam logic [7:0] CH_PLUS  = 8'h2b;
	localparam logic [7:0] CH_MINUS = 8'h2d;
	localparam logic [7:0] CH_G     = 8'h47;
	localparam logic [7:0] CH_L     = 8'h4c;
	localparam logic [7:0] CH_U     = 8'h55;
	localparam logic [3:0] DIGIT_HI = 4'h3;

	typedef struct packed {
		logic [2:0] fmt;
		logic [1:0] par;
		logic [1:0] baud;
	} stc_ctrl_s;

	localparam stc_ctrl_s CTRL_RST = '{fmt: FMT_UTC_FIXED, par: PAR_NONE, baud: BAUD_SEL_9600};

	// All time digits are BCD, one nibble per decimal digit
	typedef struct packed {
		logic [15:0] year;
		logic [11:0] doy;
		logic [7:0]  hour;
		logic [7:0]  minute;
		logic [7:0]  second;
	} stc_time_s;

	typedef struct packed {
		logic       locked;
		logic [3:0] fom;
		logic [1:0] tmode;
		logic       offset_neg;
		logic [7:0] offset_mag;
	} stc_status_s;
endpackage : stc_pkg

// >>> tb/stc_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module stc_rx_model (
	input  wire logic       clk,
	input  wire logic       rxd,
	input  var  int         bit_len,
	input  var  logic [1:0] par,
	output logic      [8:0] rx_word,
	output logic            rx_stb
);
	import stc_pkg::*;
	logic [7:0] b;
	logic       bad;
	// Mid-bit sampling at the rate it is set to, like a real port matched to the sender
	always
	begin
		@(negedge rxd);
		repeat (bit_len / 2) @(posedge clk);
		bad = rxd;
		for (int i = 0; i < 8; i++)
		begin
			repeat (bit_len) @(posedge clk);
			b[i] = rxd;
		end
		if (par == PAR_ODD || par == PAR_EVEN)
		begin
			repeat (bit_len) @(posedge clk);
			// Odd parity means an odd count of ones over data and parity bit
			bad = bad | ((^b ^ rxd) != (par == PAR_ODD));
		end
		repeat (bit_len) @(posedge clk);
		bad = bad | ~rxd;
		rx_word <= {bad, b};
		rx_stb  <= 1'b1;
		@(posedge clk);
		rx_stb  <= 1'b0;
	end
endmodule : stc_rx_model
`default_nettype wire

// >>> tb/serial_time_code_tx_tb.sv
`timescale 1ns/1ps
`default_nettype none
module serial_time_code_tx_tb;
	import stc_pkg::*;
	localparam stc_time_s UT = '{16'h2024, 12'h123, 8'h04, 8'h56, 8'h59};
	localparam stc_time_s MT = '{16'h2025, 12'h089, 8'h19, 8'h07, 8'h31};
	logic        clk, rst, hsel, hwrite, epoch, txd, hreadyout, hresp, rx_stb;
	logic [1:0]  htrans, par;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [8:0]  rx_word;
	stc_time_s   utc_t, mode_t;
	stc_status_s st;
	int          bit_len, error_cnt, checks_done, cyc;
	logic [7:0]  eq[$];
	logic [8:0]  rq[$];

	stc_serial_time_tx #(.BIT_CYC_19200(20), .BIT_CYC_9600(40), .BIT_CYC_4800(80)) stc_serial_time_tx_i (
		.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
		.HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
		.HRESP(hresp), .EPOCH(epoch), .UTC_TIME(utc_t), .MODE_TIME(mode_t), .DEV_STATUS(st), .TXD(txd));
	stc_rx_model stc_rx_model_i (.clk(clk), .rxd(txd), .bit_len(bit_len), .par(par),
		.rx_word(rx_word), .rx_stb(rx_stb));

	always @(posedge clk) if (rx_stb === 1'b1) rq.push_back(rx_word);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict

	task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= a; hsize <= 3'h2;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb

	task set_ctrl(input logic [2:0] f, input logic [1:0] p, input logic [1:0] b, input int bl);
		ahb(1'b1, 32'(CTRL_OFS), {25'h0, f, p, b});
		ahb(1'b0, 32'(CTRL_OFS), 32'h0);
		check("ctrl", {25'h0, f, p, b}, rd);
		par = p;
		bit_len = bl;
	endtask : set_ctrl

	task dg(input logic [3:0] n);
		eq.push_back({DIGIT_HI, n});
	endtask : dg

	task exp_dt(input stc_time_s t, input logic sep);
		dg(t.doy[11:8]); dg(t.doy[7:4]); dg(t.doy[3:0]);
		eq.push_back(sep ? CH_SPACE : CH_COLON);
		dg(t.hour[7:4]); dg(t.hour[3:0]); eq.push_back(CH_COLON);
		dg(t.minute[7:4]); dg(t.minute[3:0]); eq.push_back(CH_COLON);
		dg(t.second[7:4]); dg(t.second[3:0]);
	endtask : exp_dt

	task exp_fixed(input stc_time_s t, input logic lk);
		eq.push_back(CH_CR); eq.push_back(CH_LF); eq.push_back(CH_SOH);
		exp_dt(t, 1'b0);
		eq.push_back(lk ? CH_SPACE : CH_QMARK);
	endtask : exp_fixed

	task exp_ext(input stc_time_s t, input stc_status_s s);
		dg(s.fom); eq.push_back(CH_SPACE);
		dg(t.year[15:12]); dg(t.year[11:8]); dg(t.year[7:4]); dg(t.year[3:0]); eq.push_back(CH_SPACE);
		exp_dt(t, 1'b1); eq.push_back(CH_SPACE);
		eq.push_back(s.offset_neg ? CH_MINUS : CH_PLUS);
		dg(s.tmode == TMODE_LOCAL ? s.offset_mag[7:4] : 4'h0);
		dg(s.tmode == TMODE_LOCAL ? s.offset_mag[3:0] : 4'h0);
		eq.push_back(CH_SPACE);
		eq.push_back(s.tmode == TMODE_CDMA ? CH_G : (s.tmode == TMODE_LOCAL ? CH_L : CH_U));
		eq.push_back(CH_CR); eq.push_back(CH_LF);
	endtask : exp_ext

	task pulse;
		@(posedge clk);
		epoch <= 1'b1;
		@(posedge clk);
		epoch <= 1'b0;
	endtask : pulse

	// Inputs are cleared on the launch edge, so a string built late from live inputs shows up
	task run(output int n);
		rq.delete();
		pulse();
		utc_t <= '0; mode_t <= '0; st <= '0;
		n = 0;
		#1;
		while (txd !== 1'b0 && n < 20000)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		check("start_delay", 32'h1, 32'(n <= 10000));
		while (rq.size() < eq.size())
		begin
			@(posedge clk);
			n++;
		end
		foreach (eq[i]) check("char", {1'b0, eq[i]}, 32'(rq[i]));
		repeat (bit_len) @(posedge clk);
		check("char_count", eq.size(), rq.size());
		eq.delete();
	endtask : run

	initial
	begin
		// The sequence needs about 64000 cycles; the rest is margin for a stalled receiver
		repeat (90000) @(posedge clk);
		error_cnt++;
		print_verdict();
	end

	initial
	begin
		rst = 1'b1; hsel = 1'b0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; haddr = '0; hwdata = '0;
		epoch = 1'b0; utc_t = '0; mode_t = '0; st = '0; par = PAR_NONE; bit_len = 40;
		error_cnt = 0; checks_done = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		ahb(1'b0, 32'(CTRL_OFS), 32'h0);
		check("ctrl_reset", 32'h2, rd);
		check("hresp", 32'h0, 32'(hresp));
		ahb(1'b0, 32'h8, 32'h0);
		check("unmapped", 32'h0, rd);
		utc_t <= UT; mode_t <= MT; st <= '{1'b1, 4'h3, TMODE_LOCAL, 1'b0, 8'h05};
		exp_fixed(UT, 1'b1);
		run(cyc);
		ahb(1'b0, 32'(STAT_OFS), 32'h0);
		check("status_one_string", 32'h00010000, rd);
		set_ctrl(FMT_MODE_TIME, PAR_ODD, BAUD_SEL_4800, 80);
		utc_t <= UT; mode_t <= MT; st <= '{1'b0, 4'h3, TMODE_LOCAL, 1'b0, 8'h05};
		exp_fixed(MT, 1'b0);
		run(cyc);
		set_ctrl(FMT_MODE_EXT, PAR_EVEN, BAUD_SEL_19200, 20);
		for (int m = 0; m < 3; m++)
		begin
			utc_t <= UT; mode_t <= MT; st <= '{1'b1, 4'h7, 2'(m), m == 1, 8'h05};
			exp_ext(MT, '{1'b1, 4'h7, 2'(m), m == 1, 8'h05});
			run(cyc);
		end
		for (int f = 3; f < 6; f++)
		begin
			set_ctrl(3'(f), PAR_NONE, BAUD_SEL_19200, 20);
			pulse();
			cyc = 0;
			repeat (2000) @(posedge clk) cyc += (txd !== 1'b1);
			check("undefined_fmt_quiet", 32'h0, cyc);
		end
		set_ctrl(FMT_UTC_FIXED, PAR_NONE, BAUD_SEL_57600, BIT_CYC_57600);
		utc_t <= UT; mode_t <= MT; st <= '{1'b1, 4'h3, TMODE_UTC, 1'b0, 8'h00};
		eq.push_back(CH_CR);
		run(cyc);
		check("on_time_in_1ms", 32'h1, 32'(cyc + BIT_CYC_57600 / 2 <= 100000));
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		#1;
		check("txd_idle_after_reset", 32'h1, 32'(txd));
		ahb(1'b0, 32'(CTRL_OFS), 32'h0);
		check("ctrl_reset_again", 32'h2, rd);
		print_verdict();
	end
endmodule : serial_time_code_tx_tb
`default_nettype wire
